// *** port_d_e_slave.v ***
// The plain strobed port was chosen for this implementation.
`include "port_d_e_defs.vh"
`default_nettype none

module port_d_e_slave #(
    parameter WIDE_W = 8,
    parameter CTRL_W = 3
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [WIDE_W-1:0] wide_pin_in,
    output reg [WIDE_W-1:0] wide_pin_out,
    output reg [WIDE_W-1:0] wide_pin_oe_n,
    input wire [CTRL_W-1:0] ctrl_pin_in,
    output reg [CTRL_W-1:0] ctrl_pin_out,
    output reg [CTRL_W-1:0] ctrl_pin_oe_n,
    output wire irq
);

    // Two-stage synchronisers for all pin inputs.
    wire [WIDE_W-1:0] wide_sync_ff;
    wire [CTRL_W-1:0] ctrl_sync_ff;

    pin_sync #(
        .W(WIDE_W),
        .IDLE({WIDE_W{1'b0}})
    ) wide_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_in(wide_pin_in),
        .sync_ff(wide_sync_ff)
    );

    // Strobes idle high, so reset brings no false strobe.
    pin_sync #(
        .W(CTRL_W),
        .IDLE({CTRL_W{1'b1}})
    ) ctrl_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_in(ctrl_pin_in),
        .sync_ff(ctrl_sync_ff)
    );

    // Software-visible state.
    reg [WIDE_W-1:0] wide_latch_ff;
    reg [WIDE_W-1:0] wide_dir_ff;
    reg [WIDE_W-1:0] wide_in_latch_ff;
    reg [CTRL_W-1:0] ctrl_latch_ff;
    reg [CTRL_W-1:0] ctrl_dir_ff;
    reg slave_mode_ff;
    reg ibf_ff;
    reg obf_ff;
    reg input_overflow_flag_ff;
    reg [2:0] evt_status_ff;
    reg [2:0] evt_mask_ff;

    // Slave strobe tracking.
    reg wr_active_ff;
    reg rd_active_ff;

    reg [WIDE_W-1:0] nxt_wide_latch;
    reg [WIDE_W-1:0] nxt_wide_dir;
    reg [WIDE_W-1:0] nxt_wide_in_latch;
    reg [CTRL_W-1:0] nxt_ctrl_latch;
    reg [CTRL_W-1:0] nxt_ctrl_dir;
    reg nxt_slave_mode;
    reg nxt_ibf;
    reg nxt_obf;
    reg nxt_input_overflow_flag;
    reg [2:0] nxt_evt_status;
    reg [2:0] nxt_evt_mask;
    reg nxt_wr_active;
    reg nxt_rd_active;
    reg [7:0] nxt_rdata;

    wire sel_wide_data;
    wire sel_ctrl_data;
    wire sel_bit_set;
    wire sel_bit_clear;
    wire sel_evt_status;
    wire sel_wide_dir;
    wire sel_ctrl_status;
    wire sel_evt_mask;

    assign sel_wide_data = (reg_addr == `OFS_WIDE_PORT_DATA);
    assign sel_ctrl_data = (reg_addr == `OFS_CONTROL_PORT_DATA);
    assign sel_bit_set = (reg_addr == `OFS_WIDE_PORT_BIT_SET);
    assign sel_bit_clear = (reg_addr == `OFS_WIDE_PORT_BIT_CLEAR);
    assign sel_evt_status = (reg_addr == `OFS_EVENT_STATUS);
    assign sel_wide_dir = (reg_addr == `OFS_WIDE_PORT_DIRECTION);
    assign sel_ctrl_status = (reg_addr == `OFS_SLAVE_PORT_CONTROL_STATUS);
    assign sel_evt_mask = (reg_addr == `OFS_EVENT_MASK);

    // Slave strobes are active low and qualified by chip select.
    wire cs_low;
    wire slave_wr_now;
    wire slave_rd_now;
    wire write_done;
    wire read_start;
    wire read_done;
    wire in_read_clear;

    assign cs_low = slave_mode_ff & ~ctrl_sync_ff[`PIN_CHIP_SELECT];
    assign slave_wr_now = cs_low & ~ctrl_sync_ff[`PIN_WRITE_STROBE];
    assign slave_rd_now = cs_low & ~ctrl_sync_ff[`PIN_READ_STROBE];
    assign write_done = wr_active_ff & ~slave_wr_now;
    assign read_start = slave_rd_now & ~rd_active_ff;
    assign read_done = rd_active_ff & ~slave_rd_now;
    assign in_read_clear = reg_rd & sel_wide_data & slave_mode_ff;

    // Control/status register as software reads it.
    reg [7:0] ctrl_status_view;

    always @* begin
        ctrl_status_view = 8'h00;
        ctrl_status_view[`BIT_INPUT_BUFFER_FULL] = ibf_ff;
        ctrl_status_view[`BIT_OUTPUT_BUFFER_FULL] = obf_ff;
        ctrl_status_view[`BIT_INPUT_OVERFLOW] = input_overflow_flag_ff;
        ctrl_status_view[`BIT_SLAVE_MODE_SELECT] = slave_mode_ff;
        ctrl_status_view[`BIT_UNUSED] = 1'b0;
        ctrl_status_view[`CTRL_DIR_MSB:`CTRL_DIR_LSB] = ctrl_dir_ff;
    end

    always @* begin
        nxt_wide_latch = wide_latch_ff;
        nxt_wide_dir = wide_dir_ff;
        nxt_wide_in_latch = wide_in_latch_ff;
        nxt_ctrl_latch = ctrl_latch_ff;
        nxt_ctrl_dir = ctrl_dir_ff;
        nxt_slave_mode = slave_mode_ff;
        nxt_ibf = ibf_ff;
        nxt_obf = obf_ff;
        nxt_input_overflow_flag = input_overflow_flag_ff;
        nxt_evt_status = evt_status_ff;
        nxt_evt_mask = evt_mask_ff;
        nxt_wr_active = slave_wr_now;
        nxt_rd_active = slave_rd_now;
        nxt_rdata = 8'h00;

        // Software writes.
        if (reg_wr) begin
            if (sel_wide_data) begin
                nxt_wide_latch = reg_wdata[WIDE_W-1:0];
                if (slave_mode_ff) begin
                    nxt_obf = 1'b1;
                end
            end else if (sel_ctrl_data) begin
                nxt_ctrl_latch = reg_wdata[CTRL_W-1:0];
            end else if (sel_bit_set) begin
                nxt_wide_latch = wide_sync_ff | reg_wdata[WIDE_W-1:0];
            end else if (sel_bit_clear) begin
                nxt_wide_latch = wide_sync_ff & ~reg_wdata[WIDE_W-1:0];
            end else if (sel_evt_status) begin
                nxt_evt_status = evt_status_ff & ~reg_wdata[2:0];
            end else if (sel_wide_dir) begin
                nxt_wide_dir = reg_wdata[WIDE_W-1:0];
            end else if (sel_ctrl_status) begin
                nxt_slave_mode = reg_wdata[`BIT_SLAVE_MODE_SELECT];
                nxt_ctrl_dir = reg_wdata[`CTRL_DIR_MSB:`CTRL_DIR_LSB];
                nxt_input_overflow_flag = input_overflow_flag_ff & reg_wdata[`BIT_INPUT_OVERFLOW];
            end else if (sel_evt_mask) begin
                nxt_evt_mask = reg_wdata[2:0];
            end
        end

        // Only a read of the input latch, or leaving slave mode, clears input full.
        if (in_read_clear) begin
            nxt_ibf = 1'b0;
        end

        // External master write: capture while active, flag at release.
        if (slave_wr_now) begin
            nxt_wide_in_latch = wide_sync_ff;
        end
        if (write_done) begin
            nxt_ibf = 1'b1;
            nxt_evt_status[`EVT_WRITE_DONE] = 1'b1;
            if (ibf_ff && !in_read_clear) begin
                nxt_input_overflow_flag = 1'b1;
                nxt_evt_status[`EVT_OVERFLOW] = 1'b1;
            end
        end

        // External master read: output full drops at start.
        // A refill by software in the same cycle wins over the clear.
        if (read_start && !(reg_wr && sel_wide_data)) begin
            nxt_obf = 1'b0;
        end
        if (read_done) begin
            nxt_evt_status[`EVT_READ_DONE] = 1'b1;
        end

        // Full flags forced clear outside slave mode; overflow stays.
        if (!nxt_slave_mode) begin
            nxt_ibf = 1'b0;
            nxt_obf = 1'b0;
            nxt_wr_active = 1'b0;
            nxt_rd_active = 1'b0;
        end

        // Software reads, answered one cycle later.
        if (reg_rd) begin
            if (sel_wide_data) begin
                if (slave_mode_ff) begin
                    nxt_rdata = wide_in_latch_ff;
                end else begin
                    nxt_rdata = wide_sync_ff;
                end
            end else if (sel_ctrl_data) begin
                nxt_rdata = {5'h00, ctrl_sync_ff};
            end else if (sel_bit_set || sel_bit_clear) begin
                nxt_rdata = wide_sync_ff;
            end else if (sel_evt_status) begin
                nxt_rdata = {5'h00, evt_status_ff};
            end else if (sel_wide_dir) begin
                nxt_rdata = wide_dir_ff;
            end else if (sel_ctrl_status) begin
                nxt_rdata = ctrl_status_view;
            end else if (sel_evt_mask) begin
                nxt_rdata = {5'h00, evt_mask_ff};
            end
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wide_latch_ff <= `RST_PORT_LATCH;
            wide_dir_ff <= `RST_WIDE_PORT_DIRECTION;
            wide_in_latch_ff <= `RST_PORT_LATCH;
            ctrl_latch_ff <= `RST_CONTROL_DIRECTION & 3'h0;
            ctrl_dir_ff <= `RST_CONTROL_DIRECTION;
            slave_mode_ff <= 1'b0;
            ibf_ff <= 1'b0;
            obf_ff <= 1'b0;
            input_overflow_flag_ff <= 1'b0;
            evt_status_ff <= `RST_EVENT;
            evt_mask_ff <= `RST_EVENT;
            wr_active_ff <= 1'b0;
            rd_active_ff <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            wide_latch_ff <= nxt_wide_latch;
            wide_dir_ff <= nxt_wide_dir;
            wide_in_latch_ff <= nxt_wide_in_latch;
            ctrl_latch_ff <= nxt_ctrl_latch;
            ctrl_dir_ff <= nxt_ctrl_dir;
            slave_mode_ff <= nxt_slave_mode;
            ibf_ff <= nxt_ibf;
            obf_ff <= nxt_obf;
            input_overflow_flag_ff <= nxt_input_overflow_flag;
            evt_status_ff <= nxt_evt_status;
            evt_mask_ff <= nxt_evt_mask;
            wr_active_ff <= nxt_wr_active;
            rd_active_ff <= nxt_rd_active;
            reg_rdata <= nxt_rdata;
        end
    end

    // Pin drivers, registered. Enable is active low.
    reg [WIDE_W-1:0] nxt_wide_oe_n;
    reg [CTRL_W-1:0] nxt_ctrl_oe_n;

    always @* begin
        if (slave_mode_ff) begin
            // Bus driven only during a selected external read.
            nxt_wide_oe_n = {WIDE_W{~slave_rd_now}};
            nxt_ctrl_oe_n = {CTRL_W{1'b1}};
        end else begin
            nxt_wide_oe_n = wide_dir_ff;
            nxt_ctrl_oe_n = ctrl_dir_ff;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wide_pin_out <= `RST_PORT_LATCH;
            wide_pin_oe_n <= {WIDE_W{1'b1}};
            ctrl_pin_out <= {CTRL_W{1'b0}};
            ctrl_pin_oe_n <= {CTRL_W{1'b1}};
        end else begin
            wide_pin_out <= nxt_wide_latch;
            wide_pin_oe_n <= nxt_wide_oe_n;
            ctrl_pin_out <= nxt_ctrl_latch;
            ctrl_pin_oe_n <= nxt_ctrl_oe_n;
        end
    end

    // Level interrupt while any unmasked event is pending.
    wire [2:0] evt_pending;

    assign evt_pending = evt_status_ff & evt_mask_ff;
    assign irq = |evt_pending;

endmodule // port_d_e_slave

// Two-flop synchroniser; IDLE is the level held through reset.
module pin_sync #(
    parameter W = 8,
    parameter [W-1:0] IDLE = {W{1'b0}}
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] sync_ff
);

    // Only the second stage reads the first.
    reg [W-1:0] meta_ff;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= IDLE;
            sync_ff <= IDLE;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

endmodule // pin_sync

`default_nettype wire

// *** port_d_e_defs.vh ***
`ifndef PORT_D_E_DEFS_VH
`define PORT_D_E_DEFS_VH

// Register offsets on the software port.
`define OFS_WIDE_PORT_DATA 8'h08
`define OFS_CONTROL_PORT_DATA 8'h09
`define OFS_WIDE_PORT_BIT_SET 8'h0a
`define OFS_WIDE_PORT_BIT_CLEAR 8'h0b
`define OFS_EVENT_STATUS 8'h0c
`define OFS_WIDE_PORT_DIRECTION 8'h88
`define OFS_SLAVE_PORT_CONTROL_STATUS 8'h89
`define OFS_EVENT_MASK 8'h8c

// Field positions of the slave port control/status register.
`define BIT_INPUT_BUFFER_FULL 7
`define BIT_OUTPUT_BUFFER_FULL 6
`define BIT_INPUT_OVERFLOW 5
`define BIT_SLAVE_MODE_SELECT 4
`define BIT_UNUSED 3
`define CTRL_DIR_MSB 2
`define CTRL_DIR_LSB 0

// Control pin positions.
`define PIN_READ_STROBE 0
`define PIN_WRITE_STROBE 1
`define PIN_CHIP_SELECT 2

// Event status and mask positions.
`define EVT_WRITE_DONE 0
`define EVT_READ_DONE 1
`define EVT_OVERFLOW 2

// Reset values.
`define RST_WIDE_PORT_DIRECTION 8'hff
`define RST_CONTROL_DIRECTION 3'h7
`define RST_PORT_LATCH 8'h00
`define RST_EVENT 3'h0

`endif

// *** port_d_e_slave_props.sv ***
`default_nettype none
module port_d_e_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] wide_pin_out,
    input wire logic [7:0] wide_pin_oe_n,
    input wire logic [2:0] ctrl_pin_in,
    input wire logic [2:0] ctrl_pin_oe_n,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mode_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h89) begin
            mode_ff <= reg_wdata[4];
        end
    end
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    latch_write_a: assert property (reg_wr && reg_addr == 8'h08
        |=> wide_pin_out == $past(reg_wdata)) else $error("latch not written");
    wide_dir_a: assert property (reg_wr && reg_addr == 8'h88 && !mode_ff
        |=> ##1 wide_pin_oe_n == $past(reg_wdata, 2)) else $error("wide drive wrong");
    ctrl_dir_a: assert property (reg_wr && reg_addr == 8'h89 && !reg_wdata[4]
        |=> ##1 ctrl_pin_oe_n == $past(reg_wdata[2:0], 2)) else $error("control drive wrong");
    slave_ctrl_a: assert property (mode_ff && $past(mode_ff) |-> ctrl_pin_oe_n == 3'h7)
        else $error("control pin driven in slave mode");
    bit3_zero_a: assert property (reg_rd && reg_addr == 8'h89 |=> !reg_rdata[3])
        else $error("bit three set");
    slave_idle_a: assert property ((mode_ff && ctrl_pin_in[0]) [*4]
        |-> wide_pin_oe_n == 8'hff) else $error("wide driven without read");
    irq_mask_a: assert property (reg_wr && reg_addr == 8'h8c && reg_wdata == 8'h00
        ##1 !(reg_wr && reg_addr == 8'h8c) |-> !irq [*2]) else $error("masked interrupt raised");
endmodule // port_d_e_checker
bind port_d_e_slave port_d_e_checker chk_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wide_pin_out(wide_pin_out), .wide_pin_oe_n(wide_pin_oe_n),
    .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_oe_n(ctrl_pin_oe_n), .irq(irq));
`default_nettype wire

// *** upstream_cpu.sv ***
`default_nettype none
module upstream_cpu (
    input wire logic clk_sys,
    input wire logic [7:0] pin_lvl,
    output logic [2:0] ctrl_n = 3'h7,
    output logic [7:0] bus_out = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic lines(input logic [7:0] d);
        @(posedge clk_sys);
        bus_out <= d;
    endtask
    // Strobes stay low five cycles so the synchroniser sees them; data outlives the strobe.
    task automatic xfer(input logic [2:0] c, input logic [7:0] d, input logic drv,
                        output logic [7:0] q);
        @(posedge clk_sys);
        ctrl_n <= c;
        if (drv) begin
            bus_out <= d;
        end
        repeat (5) @(posedge clk_sys);
        q = pin_lvl;
        ctrl_n <= 3'h7;
        @(posedge clk_sys);
        bus_out <= ~bus_out;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule // upstream_cpu
`default_nettype wire

// *** port_d_e_slave_bench.sv ***
`default_nettype none
module port_d_e_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] q;
    wire [7:0] reg_rdata, wide_pin_out, wide_pin_oe_n, bus_out;
    wire [2:0] ctrl_pin_out, ctrl_pin_oe_n, ctrl_n;
    wire irq;
    wire [7:0] wide_lvl = (wide_pin_out & ~wide_pin_oe_n) | (bus_out & wide_pin_oe_n);
    wire [2:0] ctrl_lvl = (ctrl_pin_out & ~ctrl_pin_oe_n) | (ctrl_n & ctrl_pin_oe_n);
    int n_errors = 0;
    int cmp_count = 0;
    port_d_e_slave dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wide_pin_in(wide_lvl), .wide_pin_out(wide_pin_out), .wide_pin_oe_n(wide_pin_oe_n),
        .ctrl_pin_in(ctrl_lvl), .ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe_n(ctrl_pin_oe_n),
        .irq(irq));
    upstream_cpu cpu (.clk_sys(clk_sys), .pin_lvl(wide_lvl), .ctrl_n(ctrl_n), .bus_out(bus_out));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata);
    endtask
    task automatic s_reset();
        rd(8'h88, 8'hff);
        rd(8'h89, 8'h07);
        rd(8'h55, 8'h00);
    endtask
    task automatic s_general();
        wr(8'h88, 8'hf0);
        wr(8'h08, 8'ha5);
        cpu.lines(8'h3c);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("oe", 8'hf0, wide_pin_oe_n);
        rd(8'h08, 8'h35);
        wr(8'h0a, 8'h02);
        chk("latch", 8'h37, wide_pin_out);
        repeat (3) @(posedge clk_sys);
        rd(8'h0a, 8'h37);
        wr(8'h0b, 8'h04);
        chk("latch", 8'h33, wide_pin_out);
    endtask
    task automatic s_ctrl();
        wr(8'h89, 8'h05);
        wr(8'h09, 8'h05);
        chk("ctrl oe", 8'h05, {5'h00, ctrl_pin_oe_n});
        repeat (3) @(posedge clk_sys);
        rd(8'h09, 8'h05);
        wr(8'h89, 8'h07);
    endtask
    task automatic s_slave();
        wr(8'h8c, 8'h07);
        wr(8'h89, 8'h17);
        wr(8'h08, 8'h3c);
        chk("wide oe", 8'hff, wide_pin_oe_n);
        cpu.xfer(3'h5, 8'h11, 1'b1, q);
        rd(8'h89, 8'h57);
        cpu.xfer(3'h1, 8'h5a, 1'b1, q);
        rd(8'h89, 8'hd7);
        chk("irq", 8'h01, {7'h00, irq});
        cpu.xfer(3'h1, 8'h66, 1'b1, q);
        rd(8'h89, 8'hf7);
        rd(8'h0c, 8'h05);
        rd(8'h08, 8'h66);
        rd(8'h89, 8'h77);
        cpu.xfer(3'h2, 8'h00, 1'b0, q);
        chk("bus", 8'h3c, q);
        rd(8'h89, 8'h37);
        wr(8'h0c, 8'h07);
        wr(8'h8c, 8'h00);
        cpu.xfer(3'h1, 8'h99, 1'b1, q);
        rd(8'h0c, 8'h01);
        chk("irq", 8'h00, {7'h00, irq});
        wr(8'h8c, 8'h01);
        chk("irq", 8'h01, {7'h00, irq});
        rd(8'h8c, 8'h01);
        wr(8'h0c, 8'h01);
        chk("irq", 8'h00, {7'h00, irq});
    endtask
    task automatic s_exit();
        wr(8'h89, 8'h2f);
        rd(8'h89, 8'h27);
        wr(8'h89, 8'h07);
        rd(8'h89, 8'h07);
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        s_reset();
        s_general();
        s_ctrl();
        s_slave();
        s_exit();
        end_sim();
    end
endmodule // port_d_e_slave_bench
`default_nettype wire
